/* design/serial_prog_defs.vh */
// Constants for the serial programming port: opcodes, bytes, wait times.
// Assumes inclusion by bare name from design files only.
`ifndef SERIAL_PROG_DEFS_VH
`define SERIAL_PROG_DEFS_VH

// Instruction bytes
`define OP_PREFIX      8'hac
`define OP_ENABLE_B2   8'h53
`define OP_LOAD_PAGE   8'h40
`define OP_WRITE_PAGE  8'h4c
`define OP_READ_PROG   8'h20
`define OP_READ_EE     8'ha0
`define OP_WRITE_EE    8'hc0
`define ERASE_B2_TOP   3'h4
`define FUSE_B2_TOP    3'h5
`define LOCK_B2_TOP    3'h7
`define H_BIT          3
`define BLANK_BYTE     8'hff

// Wait times in microseconds, clock in MHz
`define CLK_MHZ        100
`define FLASH_WAIT_US  4500
`define EE_WAIT_US     9000
`define FUSE_WAIT_US   4500
`define ERASE_WAIT_US  9000

`endif

/* design/prog_fifo.v */
// 32-bit command word FIFO between link shifter and memory command engine.
// Assumes one clock domain; valid/ready handshakes on both sides.
`timescale 1ns/100ps
`default_nettype none

module prog_fifo
#(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  // Clock and reset
  input  wire             mclk,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp_r;
  reg [AW:0]      rp_r;
  reg             ov_r;
  wire [AW:0]     cnt;
  wire            push;
  wire            pop;

  assign cnt       = wp_r - rp_r;
  assign in_ready  = (cnt != DEPTH[AW:0]);
  assign push      = in_valid & in_ready;
  assign out_valid = ov_r;
  assign pop       = (cnt != {(AW+1){1'b0}}) & (~ov_r | out_ready);

  always @(posedge mclk)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= in_data;
  end

  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wp_r     <= {(AW+1){1'b0}};
      rp_r     <= {(AW+1){1'b0}};
      ov_r     <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
      begin
        rp_r     <= rp_r + 1'b1;
        out_data <= mem[rp_r[AW-1:0]];
        ov_r     <= 1'b1;
      end
      else if (out_ready)
        ov_r <= 1'b0;
    end
  end

endmodule // prog_fifo

`default_nettype wire

/* design/serial_prog_port.v */
// Serial in-system programming slave: link shifter, command engine,
// program and EEPROM arrays. Assumes link pins are asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
`include "serial_prog_defs.vh"

// Summary of operation
// - Programming under reset or entry strap, after enable
// - Data uses dedicated port E pins
// - EEPROM write erases location first
// - Chip erase fills both arrays 0xFF
// - Input sampled on serial clock rise
// - Output shifted on serial clock fall
// - Entry pin and serial clock both low at reset enters mode
// - Echo 0x53 during third byte
// - Write-page commits page, 8 MSBs
// - EEPROM bytewise with self-timed wait
// - Read returns addressed memory content
// - Busy page reads 0xFF
// - Busy EEPROM byte reads 0xFF
module serial_prog_port
#(
  parameter PAGE_AW    = 7,
  parameter FLASH_AW   = 15,
  parameter EE_AW      = 11,
  parameter FLASH_WAIT = `FLASH_WAIT_US * `CLK_MHZ,
  parameter EE_WAIT    = `EE_WAIT_US * `CLK_MHZ,
  parameter FUSE_WAIT  = `FUSE_WAIT_US * `CLK_MHZ,
  parameter ERASE_WAIT = `ERASE_WAIT_US * `CLK_MHZ
)
(
  // Clock and reset
  input  wire mclk,
  input  wire rst_n,
  // Device pins
  input  wire ext_reset_n,
  input  wire program_entry_pin_n,
  input  wire port_b_bit_one,
  input  wire port_e_bit_zero,
  output reg  port_e_bit_one,
  output wire port_e_bit_one_oe_n,
  // Status
  output reg  prog_mode,
  output wire busy
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] sck_s_r, din_s_r, rst_s_r, pen_s_r;
  reg       sck_d_r;
  always @(posedge mclk)
  begin
    sck_s_r <= {sck_s_r[0], port_b_bit_one};
    din_s_r <= {din_s_r[0], port_e_bit_zero};
    rst_s_r <= {rst_s_r[0], ext_reset_n};
    pen_s_r <= {pen_s_r[0], program_entry_pin_n};
    sck_d_r <= sck_s_r[1];
  end
  wire sck_rise = sck_s_r[1] & ~sck_d_r;
  wire sck_fall = ~sck_s_r[1] & sck_d_r;

  // ----------------------------------------------------------------
  // Mode entry
  // ----------------------------------------------------------------
  reg strap_done_r, strap_mode_r;
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      strap_done_r <= 1'b0;
      strap_mode_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      strap_mode_r <= ~pen_s_r[1] & ~sck_s_r[1];
    end
  end

  wire pin_access = strap_mode_r | ~rst_s_r[1];
  always @(posedge mclk)
  begin
    if (!rst_n)
      prog_mode <= 1'b0;
    else
      prog_mode <= pin_access;
  end
  assign port_e_bit_one_oe_n = ~prog_mode;

  // ----------------------------------------------------------------
  // Link shifter
  // ----------------------------------------------------------------
  reg [7:0]  rx_r, tx_r;
  reg [2:0]  bit_r;
  reg [1:0]  byte_r;
  reg [23:0] hdr_r;
  reg        word_v_r;
  reg [31:0] word_r;
  reg [7:0]  rdata_r;
  reg        sync_r;
  wire [7:0] rx_nxt = {rx_r[6:0], din_s_r[1]};
  wire       f_ready;

  always @(posedge mclk)
  begin
    if (!rst_n || !pin_access)
    begin
      rx_r     <= 8'h00;
      tx_r     <= 8'h00;
      bit_r    <= 3'h0;
      byte_r   <= 2'h0;
      hdr_r    <= 24'h000000;
      word_v_r <= 1'b0;
      word_r   <= 32'h00000000;
      sync_r   <= 1'b0;
      port_e_bit_one <= 1'b0;
    end
    else
    begin
      if (word_v_r & f_ready)
        word_v_r <= 1'b0;
      if (sck_rise)
      begin
        rx_r  <= rx_nxt;
        bit_r <= bit_r + 3'h1;
        if (bit_r == 3'h7)
        begin
          byte_r <= byte_r + 2'h1;
          case (byte_r)
            2'h0: hdr_r[23:16] <= rx_nxt;
            2'h1:
            begin
              hdr_r[15:8] <= rx_nxt;
              sync_r <= (hdr_r[23:16] == `OP_PREFIX) &&
                        (rx_nxt == `OP_ENABLE_B2);
            end
            2'h2: hdr_r[7:0] <= rx_nxt;
            default:
            begin
              word_r   <= {hdr_r, rx_nxt};
              word_v_r <= 1'b1;
            end
          endcase
        end
      end
      if (sck_fall)
      begin
        if (bit_r == 3'h0)
        begin
          case (byte_r)
            2'h2:    tx_r <= hdr_r[15:8];
            2'h3:    tx_r <= rdata_r;
            default: tx_r <= 8'h00;
          endcase
          port_e_bit_one <= (byte_r == 2'h2) ? hdr_r[15] :
                            (byte_r == 2'h3) ? rdata_r[7] : 1'b0;
        end
        else
        begin
          port_e_bit_one <= tx_r[3'h7 - bit_r];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command queue
  // ----------------------------------------------------------------
  wire        c_valid;
  reg         c_ready;
  wire [31:0] c_word;

  prog_fifo #(.WIDTH(32), .DEPTH(8), .AW(3)) u_fifo
  (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (word_v_r),
    .in_ready  (f_ready),
    .in_data   (word_r),
    .out_valid (c_valid),
    .out_ready (c_ready),
    .out_data  (c_word)
  );

  // ----------------------------------------------------------------
  // Memories and command engine
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_WAIT  = 2'h2;

  reg [7:0]  flash [0:(1<<(FLASH_AW+1))-1];
  reg [7:0]  eeprom [0:(1<<EE_AW)-1];
  reg [7:0]  pbuf [0:(1<<(PAGE_AW+1))-1];
  reg [1:0]  st_r;
  reg [31:0] wait_r;
  reg [FLASH_AW:0] er_r;
  reg        enabled_r;
  reg        pg_busy_r, ee_busy_r;
  reg [FLASH_AW-PAGE_AW-1:0] pg_r;
  reg [EE_AW-1:0]            ee_a_r;
  integer i;

  wire [7:0] b1 = c_word[31:24];
  wire [7:0] b2 = c_word[23:16];
  wire [7:0] b3 = c_word[15:8];
  wire [7:0] b4 = c_word[7:0];
  wire [FLASH_AW-1:0] waddr = {b2[FLASH_AW-9:0], b3};
  wire [EE_AW-1:0]    eaddr = {b2[EE_AW-9:0], b3};
  assign busy = (st_r != ST_IDLE);

  // Read data prepared once third byte is in, before fourth shifts out
  always @(posedge mclk)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else if (byte_r == 2'h3)
    begin
      if (hdr_r[23:16] == `OP_READ_EE)
        rdata_r <= (ee_busy_r &&
                    ee_a_r == {hdr_r[EE_AW-9+8:8], hdr_r[7:0]}) ?
                   `BLANK_BYTE :
                   eeprom[{hdr_r[EE_AW-9+8:8], hdr_r[7:0]}];
      else if ((hdr_r[23:16] & 8'hf7) == `OP_READ_PROG)
        rdata_r <= (pg_busy_r &&
                    pg_r == hdr_r[FLASH_AW-1:PAGE_AW]) ?
                   `BLANK_BYTE :
                   flash[{hdr_r[FLASH_AW-1:0], hdr_r[16+`H_BIT]}];
      else
        rdata_r <= 8'h00;
    end
  end

  always @(posedge mclk)
  begin
    if (!rst_n || !pin_access)
    begin
      st_r      <= ST_IDLE;
      wait_r    <= 32'h0;
      er_r      <= {(FLASH_AW+1){1'b0}};
      enabled_r <= 1'b0;
      pg_busy_r <= 1'b0;
      ee_busy_r <= 1'b0;
      pg_r      <= {(FLASH_AW-PAGE_AW){1'b0}};
      ee_a_r    <= {EE_AW{1'b0}};
      c_ready   <= 1'b0;
    end
    else
    begin
      c_ready <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          c_ready <= ~c_valid | ~c_ready;
          if (c_valid & c_ready)
          begin
            if (b1 == `OP_PREFIX && b2 == `OP_ENABLE_B2)
              enabled_r <= sync_r;
            else if (enabled_r)
            begin
              if (b1 == `OP_PREFIX && b2[7:5] == `ERASE_B2_TOP)
              begin
                er_r   <= {(FLASH_AW+1){1'b0}};
                wait_r <= ERASE_WAIT;
                st_r   <= ST_ERASE;
              end
              else if (b1 == `OP_PREFIX && (b2[7:5] == `FUSE_B2_TOP ||
                       b2[7:5] == `LOCK_B2_TOP))
              begin
                wait_r <= FUSE_WAIT;
                st_r   <= ST_WAIT;
              end
              else if ((b1 & 8'hf7) == `OP_LOAD_PAGE)
                pbuf[{b3[PAGE_AW-1:0], b1[`H_BIT]}] <= b4;
              else if (b1 == `OP_WRITE_PAGE)
              begin
                pg_r      <= waddr[FLASH_AW-1:PAGE_AW];
                for (i = 0; i < (1<<(PAGE_AW+1)); i = i + 1)
                  flash[{waddr[FLASH_AW-1:PAGE_AW], i[PAGE_AW:0]}]
                    <= pbuf[i];
                pg_busy_r <= 1'b1;
                wait_r    <= FLASH_WAIT;
                st_r      <= ST_WAIT;
              end
              else if (b1 == `OP_WRITE_EE)
              begin
                eeprom[eaddr] <= b4;
                ee_a_r    <= eaddr;
                ee_busy_r <= 1'b1;
                wait_r    <= EE_WAIT;
                st_r      <= ST_WAIT;
              end
            end
          end
        end
        ST_ERASE:
        begin
          flash[er_r] <= `BLANK_BYTE;
          if (er_r[EE_AW-1:0] == er_r)
            eeprom[er_r[EE_AW-1:0]] <= `BLANK_BYTE;
          er_r <= er_r + 1'b1;
          if (&er_r)
            st_r <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // Reads keep being served; only commands stall here
          if (wait_r <= 32'h1)
          begin
            pg_busy_r <= 1'b0;
            ee_busy_r <= 1'b0;
            st_r      <= ST_IDLE;
          end
          else
            wait_r <= wait_r - 32'h1;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // serial_prog_port

`default_nettype wire

/* test/isp_programmer.sv */
// Programmer model: drives the serial clock and data into the port.
// Assumes the bench calls frame() just after an mclk rising edge.
`timescale 1ns/100ps
`default_nettype none

module isp_programmer
(
  // Clock
  input  wire logic mclk,
  // Link pins
  output var  logic sck,
  output var  logic sdi,
  input  wire logic sdo
);
  initial
  begin
    sck = 1'b0;
    sdi = 1'b0;
  end

  // --------------------------------------------------
  // Full duplex 32-bit frame, four mclk per phase
  // --------------------------------------------------
  task automatic frame(input logic [31:0] w, output logic [31:0] r);
    for (int i = 31; i >= 0; i--)
    begin
      sdi <= w[i];
      repeat (4) @(posedge mclk);
      sck <= 1'b1;
      repeat (4) @(posedge mclk);
      r = {r[30:0], sdo};
      sck <= 1'b0;
    end
    sdi <= ~sdi;
    @(posedge mclk);
  endtask
endmodule // isp_programmer

`default_nettype wire

/* test/serial_prog_port_chk.sv */
// Checker bound to the serial programming port top.
// Assumes link pins change away from mclk edges.
`timescale 1ns/100ps
`default_nettype none

module serial_prog_port_chk
#(
  parameter FLASH_WAIT = 50,
  parameter EE_WAIT    = 50
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Device pins
  input wire logic ext_reset_n,
  input wire logic program_entry_pin_n,
  input wire logic port_b_bit_one,
  input wire logic port_e_bit_zero,
  input wire logic port_e_bit_one,
  input wire logic port_e_bit_one_oe_n,
  // Status
  input wire logic prog_mode,
  input wire logic busy
);
  localparam int MIN_W = FLASH_WAIT < EE_WAIT ? FLASH_WAIT : EE_WAIT;
  logic sck_q;
  logic rst_q;
  logic strap_r;
  int   fall_age;
  int   busy_len;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------
  // Helper counters
  // --------------------------------------------------
  always @(posedge mclk)
  begin
    sck_q    <= port_b_bit_one;
    rst_q    <= rst_n;
    busy_len <= busy ? busy_len + 1 : 0;
    if (sck_q && !port_b_bit_one)
      fall_age <= 0;
    else if (fall_age < 99)
      fall_age <= fall_age + 1;
    if (rst_n && !rst_q)
      strap_r <= program_entry_pin_n;
  end

  sequence sck_high_run;
    port_b_bit_one [*3];
  endsequence

  sequence sck_low_run;
    (!port_b_bit_one && prog_mode) [*8];
  endsequence

  oe_idle_a: assert property
    ((ext_reset_n && strap_r) [*6] |-> port_e_bit_one_oe_n)
    else $error("data out driven outside programming");
  oe_on_a: assert property
    ($fell(ext_reset_n) |-> ##[1:4] !port_e_bit_one_oe_n)
    else $error("data out not driven in programming");
  out_after_fall_a: assert property
    (prog_mode && $past(prog_mode) && $changed(port_e_bit_one)
     |-> fall_age inside {[1:6]}) else $error("out moved off a clock fall");
  out_high_hold_a: assert property
    (sck_high_run |-> $stable(port_e_bit_one))
    else $error("out moved while clock high");
  out_low_hold_a: assert property
    (sck_low_run |-> $stable(port_e_bit_one))
    else $error("out moved while clock idle low");
  busy_mode_a: assert property (busy |-> prog_mode)
    else $error("busy outside programming");
  busy_min_a: assert property ($fell(busy) |-> busy_len >= MIN_W)
    else $error("self-timed wait too short");
  mode_exit_a: assert property
    ((ext_reset_n && strap_r) [*6] |-> !prog_mode)
    else $error("programming kept with reset pin high");
endmodule // serial_prog_port_chk

bind serial_prog_port serial_prog_port_chk
  #(.FLASH_WAIT(FLASH_WAIT), .EE_WAIT(EE_WAIT))
  u_chk (.mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
  .program_entry_pin_n(program_entry_pin_n),
  .port_b_bit_one(port_b_bit_one), .port_e_bit_zero(port_e_bit_zero),
  .port_e_bit_one(port_e_bit_one),
  .port_e_bit_one_oe_n(port_e_bit_one_oe_n),
  .prog_mode(prog_mode), .busy(busy));

`default_nettype wire

/* test/tb_serial_prog_port.sv */
// Testbench for the serial programming port with a programmer model.
// Assumes self-timed waits shortened through parameters.
`timescale 1ns/100ps
`default_nettype none

module tb_serial_prog_port;
  localparam int W = 400;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ext_n = 1'b1;
  logic        pen_n = 1'b1;
  logic        sck;
  logic        sdi;
  logic        sdo;
  logic        oe_n;
  logic        mode;
  logic        busy;
  wire logic   sdo_w = oe_n ? 1'bz : sdo;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [31:0] r;
  logic [7:0]  fl [int];
  logic [7:0]  ee [int];

  serial_prog_port #(.FLASH_WAIT(W), .EE_WAIT(W), .FUSE_WAIT(W),
    .ERASE_WAIT(W)) dut (.mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_n),
    .program_entry_pin_n(pen_n), .port_b_bit_one(sck),
    .port_e_bit_zero(sdi), .port_e_bit_one(sdo),
    .port_e_bit_one_oe_n(oe_n), .prog_mode(mode), .busy(busy));
  isp_programmer pm (.mclk(mclk), .sck(sck), .sdi(sdi), .sdo(sdo_w));

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // --------------------------------------------------
  // Shared tasks
  // --------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 30)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, busy}, 8'h01);
    n = 0;
    while (busy !== 1'b0 && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h0, busy}, 8'h00);
  endtask

  task automatic rd(input logic [31:0] w, input logic [7:0] exp);
    pm.frame(w, r);
    chk(r[7:0], exp);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (95000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end

  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial
  begin
    logic [14:0] a;
    logic [7:0]  pg;
    logic [7:0]  d;
    logic [10:0] e;
    void'($urandom(65897));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    pm.frame(32'hac530000, r);
    chk({7'h0, r[15:8] === 8'h53}, 8'h00);
    chk({7'h0, mode}, 8'h00);
    $display("test 1 done");
    ext_n <= 1'b0;
    repeat (8) @(posedge mclk);
    pm.frame(32'hac530000, r);
    chk(r[15:8], 8'h53);
    chk({6'h0, mode, oe_n}, 8'h02);
    $display("test 2 done");
    pm.frame(32'hac800000, r);
    idle(70000);
    fl.delete();
    ee.delete();
    a = 15'($urandom);
    rd({8'h28, 1'b0, a, 8'h00}, 8'hff);
    e = 11'($urandom);
    rd({8'ha0, 5'h0, e, 8'h00}, 8'hff);
    $display("test 3 done");
    pg = 8'($urandom);
    for (int k = 0; k < 4; k++)
    begin
      a = {pg, 7'($urandom)};
      d = 8'($urandom);
      pm.frame({8'h40, 9'h0, a[6:0], d}, r);
      fl[{a, 1'b0}] = d;
      d = 8'($urandom);
      pm.frame({8'h48, 9'h0, a[6:0], d}, r);
      fl[{a, 1'b1}] = d;
    end
    pm.frame({8'h4c, 1'b0, pg[7:1], pg[0], 15'h0}, r);
    rd({8'h20, 1'b0, a, 8'h00}, 8'hff);
    idle(2000);
    foreach (fl[i])
      rd({4'h2, i[0], 4'h0, i[15:1], 8'h00}, fl[i]);
    $display("test 4 done");
    e = 11'($urandom);
    for (int k = 0; k < 2; k++)
    begin
      ee[e] = 8'($urandom);
      pm.frame({8'hc0, 5'h0, e, ee[e]}, r);
      rd({8'ha0, 5'h0, e, 8'h00}, 8'hff);
      idle(2000);
      rd({8'ha0, 5'h0, e, 8'h00}, ee[e]);
    end
    $display("test 5 done");
    ext_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({7'h0, mode}, 8'h00);
    $display("test 6 done");
    pen_n <= 1'b0;
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({7'h0, mode}, 8'h01);
    pm.frame({8'hc0, 5'h0, e, ~ee[e]}, r);
    rd({8'ha0, 5'h0, e, 8'h00}, ee[e]);
    pm.frame(32'hac530000, r);
    chk(r[15:8], 8'h53);
    $display("test 7 done");
    end_of_test();
  end
endmodule // tb_serial_prog_port

`default_nettype wire
